// file: verilog/tsac_params.svh
// Offsets, field positions, reset values and timing counts of the sensor core
// How it works
// (R01) High limit equals (code minus 63) times 0.64 C
// (R02) Low limit decoded the same way
// (R03) High code zero disables high detection
// (R04) Low code zero disables low detection
// (R05) Control bit 7 selects 1 Hz slow mode
// (R06) Coherent update: low byte read first
// (R07) Averaging code picks averages and continuous rate
// (R08) Control bit 3 makes pointer auto-advance
// (R09) Without auto-advance pointer stays fixed
// (R10) Timeout-disable bit switches off bus timeout
// (R11) Writing control bit 0 starts one conversion
// (R12) Under-limit flag sticky, cleared by status read
// (R13) Over-limit flag sticky, cleared by status read
// (R14) Busy bit in one-shot; bits 7..3 zero
// (R15) Result is 16-bit two's complement, 100/C
// (R16) Alert low at result >= high or < low
// (R17) Alert held until alert-response ack or status read
// (R18) Still-true condition reasserts at next conversion
// (R19) One-shot default; chain off after conversion
// (R20) Mode decoded from continuous and slow bits
// (R21) Continuous mode: chain on, results at rate
// (R22) Host powers down before changing mode
// (R23) Host keeps one-shot requests at 1 Hz
// (R24) Host never sets continuous and slow together
// (R25) Flags and alert set with the result update
`ifndef TSAC_PARAMS_SVH
`define TSAC_PARAMS_SVH

// Register offsets
`define TSAC_ADDR_IDENTITY 8'h01
`define TSAC_ADDR_HIGH_THR 8'h02
`define TSAC_ADDR_LOW_THR 8'h03
`define TSAC_ADDR_CONTROL 8'h04
`define TSAC_ADDR_FLAGS 8'h05
`define TSAC_ADDR_RES_LOW 8'h06
`define TSAC_ADDR_RES_HIGH 8'h07

// Control field positions
`define TSAC_CTL_SLOW 7
`define TSAC_CTL_COHERENT 6
`define TSAC_CTL_AVG_HI 5
`define TSAC_CTL_AVG_LO 4
`define TSAC_CTL_AUTOINC 3
`define TSAC_CTL_CONT 2
`define TSAC_CTL_TMO_DIS 1
`define TSAC_CTL_ONESHOT 0

// Status field positions
`define TSAC_STS_UNDER 2
`define TSAC_STS_OVER 1
`define TSAC_STS_BUSY 0

// Reset values
`define TSAC_RST_THR 8'h00
`define TSAC_RST_CONTROL 8'h00
`define TSAC_RST_RESULT 16'h0000

// Identity value: arbitrary, neutral
`define TSAC_IDENTITY_VALUE 8'h5c

// Threshold decode: offset code and LSB per step (0.64 C at 100 LSB/C)
`define TSAC_THR_OFFSET 16'sd63
`define TSAC_THR_STEP_LSB 16'sd64

// Timing: clock period and conversion periods in ns
`define TSAC_CLK_PERIOD_NS 10
`define TSAC_SLOW_PERIOD_NS 1000000000
`define TSAC_FAST_PERIOD_NS 5000000
`define TSAC_SLOW_CYC (`TSAC_SLOW_PERIOD_NS / `TSAC_CLK_PERIOD_NS)
`define TSAC_FAST_CYC (`TSAC_FAST_PERIOD_NS / `TSAC_CLK_PERIOD_NS)

`endif

// file: verilog/tsac_pkg.sv
// Types shared by the sensor core files
package tsac_pkg;
    // Operating mode decoded from the control register
    typedef enum logic [1:0] {
        TSAC_MODE_ONESHOT,
        TSAC_MODE_CONT,
        TSAC_MODE_SLOW,
        TSAC_MODE_NONE
    } tsac_mode_t;
    // Conversion sequencer state
    typedef enum logic [1:0] {
        TSAC_CONV_IDLE,
        TSAC_CONV_WAIT
    } tsac_conv_t;
endpackage

// file: verilog/tsac_xfer_if.sv
// Carrier between link-side port logic and the register core
`timescale 1ns/1ps
interface tsac_xfer_if;
    logic reqToggle; // Flips once per register access request
    logic [7:0] reqAddr; // Register address of the request
    logic [7:0] reqWrData; // Write byte of the request
    logic reqRead; // Request is a read
    logic araToggle; // Flips once per alert-response ack
    logic ackToggle; // Flips when the core has served a request
    logic [7:0] ackRdData; // Read byte, stable after ackToggle flips
    logic autoInc; // Auto-advance setting, core clock level
    modport link (output reqToggle, reqAddr, reqWrData, reqRead, araToggle,
                  input ackToggle, ackRdData, autoInc);
    modport core (input reqToggle, reqAddr, reqWrData, reqRead, araToggle,
                  output ackToggle, ackRdData, autoInc);
endinterface

// file: verilog/tsac_link_port.sv
// Link-clock side: register pointer and request handshake
`timescale 1ns/1ps
`include "tsac_params.svh"
module tsac_link_port
    import tsac_pkg::*;
(
    input wire logic linkClk, // Link clock
    input wire logic rst_b, // Core reset, resynchronised here
    input wire logic subAddrLoad, // Pulse: load register pointer
    input wire logic [7:0] subAddr, // Pointer value
    input wire logic wrStrobe, // Pulse: write one byte
    input wire logic [7:0] wrData, // Byte to write
    input wire logic rdStrobe, // Pulse: read one byte
    input wire logic araAck, // Pulse: alert-response acknowledged
    output logic [7:0] rdData, // Read byte
    output logic rdValid, // Pulse: rdData valid
    output logic linkBusy, // Access in flight
    tsac_xfer_if.link xf // Crossing to the core
);
    logic [2:0] rstSync; // Reset synchroniser
    logic linkRst_b; // Reset in link domain
    logic [2:0] ackSync; // Ack toggle synchroniser
    logic ackSeen; // Last ack toggle acted on
    logic [2:0] incSync; // Auto-advance synchroniser
    logic autoIncLink; // Settled auto-advance level
    logic [7:0] pointer; // Register pointer
    logic ackEvent; // Core finished an access

    // Reset release needs both late stages high
    always_ff @(posedge linkClk) begin
        rstSync <= {rstSync[1:0], rst_b};
    end
    assign linkRst_b = rstSync[1] & rstSync[2];

    // Three-stage synchronisers for ack toggle and auto-advance level
    always_ff @(posedge linkClk) begin
        if (!linkRst_b) begin
            ackSync <= 3'h0;
            incSync <= 3'h0;
        end else begin
            ackSync <= {ackSync[1:0], xf.ackToggle};
            incSync <= {incSync[1:0], xf.autoInc};
        end
    end
    assign ackEvent = (ackSync[1] == ackSync[2]) && (ackSync[2] != ackSeen);

    // Settled auto-advance level once stages two and three agree
    always_ff @(posedge linkClk) begin
        if (!linkRst_b) begin
            autoIncLink <= 1'b0;
        end else if (incSync[1] == incSync[2]) begin
            autoIncLink <= incSync[2];
        end
    end

    // Request launch, pointer update and read return
    always_ff @(posedge linkClk) begin
        if (!linkRst_b) begin
            xf.reqToggle <= 1'b0;
            xf.reqAddr <= 8'h00;
            xf.reqWrData <= 8'h00;
            xf.reqRead <= 1'b0;
            pointer <= 8'h00;
            ackSeen <= 1'b0;
            linkBusy <= 1'b0;
            rdData <= 8'h00;
            rdValid <= 1'b0;
        end else begin
            rdValid <= 1'b0;
            if (linkBusy) begin
                // Waiting for the core; new strobes are ignored
                if (ackEvent) begin
                    ackSeen <= ackSync[2];
                    linkBusy <= 1'b0;
                    if (xf.reqRead) begin
                        rdData <= xf.ackRdData;
                        rdValid <= 1'b1;
                    end
                    if (autoIncLink) begin
                        pointer <= pointer + 8'h01; // R08
                    end // R09: otherwise pointer stays
                end
            end else if (subAddrLoad) begin
                pointer <= subAddr;
            end else if (wrStrobe || rdStrobe) begin
                // Capture the access, then flip the request toggle
                xf.reqAddr <= pointer;
                xf.reqWrData <= wrData;
                xf.reqRead <= rdStrobe;
                xf.reqToggle <= ~xf.reqToggle;
                linkBusy <= 1'b1;
            end
        end
    end

    // Alert-response acks travel as a toggle
    always_ff @(posedge linkClk) begin
        if (!linkRst_b) begin
            xf.araToggle <= 1'b0;
        end else if (araAck) begin
            xf.araToggle <= ~xf.araToggle;
        end
    end
endmodule

// file: verilog/tsac_core.sv
// Register file, conversion sequencing and limit alert of the sensor core
`timescale 1ns/1ps
`include "tsac_params.svh"
module tsac_core
    import tsac_pkg::*;
#(
    parameter int SLOW_CYC = `TSAC_SLOW_CYC, // 1 Hz period in cycles
    parameter int FAST_CYC = `TSAC_FAST_CYC // 200 Hz period in cycles
) (
    input wire logic clk_sys, // Core clock
    input wire logic rst_b, // Sync reset, low
    input wire logic linkClk, // Link clock
    input wire logic subAddrLoad, // Load pointer
    input wire logic [7:0] subAddr, // Pointer value
    input wire logic wrStrobe, // Write pulse
    input wire logic [7:0] wrData, // Write byte
    input wire logic rdStrobe, // Read pulse
    input wire logic araAck, // Alert ack pulse
    output logic [7:0] rdData, // Read byte
    output logic rdValid, // Read byte valid
    output logic linkBusy, // Access in flight
    output logic busTimeoutDisable, // Bus timeout off
    output logic convStart, // Start pulse
    input wire logic convDone, // Done pulse
    input wire logic [15:0] convResult, // Result at done
    output logic chainPowerOn, // Chain powered
    output logic [1:0] averagingSelect, // Averages code
    output logic alertOut, // Alert value, 0
    output logic alertOe // Alert enable
);
    tsac_xfer_if xf(); // Carrier to link side

    logic [7:0] highThreshold; // High code
    logic [7:0] lowThreshold; // Low code
    logic [7:0] modeControl; // Control
    logic [15:0] result; // Last result
    logic [7:0] highShadow; // Held high byte

    logic belowLowLimitFlag; // Under flag
    logic aboveHighLimitFlag; // Over flag

    logic busy; // One-shot busy
    logic alertActive; // Alert latch

    logic [2:0] reqSync; // Request sync
    logic reqSeen; // Request served
    logic [2:0] araSync; // Ack sync
    logic araSeen; // Ack served

    logic reqEvent; // Serve access
    logic araEvent; // Alert ack
    logic wrEvent; // Write access
    logic rdEvent; // Read access
    logic flagsRead; // Status read

    logic [7:0] next_rdByte; // Read mux

    tsac_mode_t mode; // Mode
    tsac_conv_t convState; // Sequencer

    logic [26:0] rateCount; // Rate timer
    logic [26:0] ratePeriod; // Period minus one
    logic rateTick; // Period over

    logic oneShotReq; // One-shot asked

    logic signed [15:0] highLimit; // High limit
    logic signed [15:0] lowLimit; // Low limit

    logic overNow; // At or above high
    logic underNow; // Below low

    // Link side pointer and handshake
    tsac_link_port linkPort (
        .linkClk(linkClk),
        .rst_b(rst_b),
        .subAddrLoad(subAddrLoad),
        .subAddr(subAddr),
        .wrStrobe(wrStrobe),
        .wrData(wrData),
        .rdStrobe(rdStrobe),
        .araAck(araAck),
        .rdData(rdData),
        .rdValid(rdValid),
        .linkBusy(linkBusy),
        .xf(xf.link)
    );

    // Code to limit in result units: (code - 63) * 64 LSB
    function automatic logic signed [15:0] decodeLimit(input logic [7:0] code);
        logic signed [15:0] diff;
        diff = $signed({8'h00, code}) - `TSAC_THR_OFFSET;
        return 16'(diff * `TSAC_THR_STEP_LSB);
    endfunction

    // Three-stage synchronisers for the two toggles from the link side
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            reqSync <= 3'h0;
            araSync <= 3'h0;
        end else begin
            reqSync <= {reqSync[1:0], xf.reqToggle};
            araSync <= {araSync[1:0], xf.araToggle};
        end
    end

    // Event once stages two and three agree on a new level
    assign reqEvent = (reqSync[1] == reqSync[2]) && (reqSync[2] != reqSeen);
    assign araEvent = (araSync[1] == araSync[2]) && (araSync[2] != araSeen);
    assign wrEvent = reqEvent && !xf.reqRead;
    assign rdEvent = reqEvent && xf.reqRead;
    assign flagsRead = rdEvent && (xf.reqAddr == `TSAC_ADDR_FLAGS);

    // Remember served toggles
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            reqSeen <= 1'b0;
            araSeen <= 1'b0;
        end else begin
            if (reqEvent) begin
                reqSeen <= reqSync[2];
            end
            if (araEvent) begin
                araSeen <= araSync[2];
            end
        end
    end

    // Threshold and control writes
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            highThreshold <= `TSAC_RST_THR;
            lowThreshold <= `TSAC_RST_THR;
            modeControl <= `TSAC_RST_CONTROL;
        end else if (wrEvent) begin
            case (xf.reqAddr)
                `TSAC_ADDR_HIGH_THR: begin
                    highThreshold <= xf.reqWrData;
                end
                `TSAC_ADDR_LOW_THR: begin
                    lowThreshold <= xf.reqWrData;
                end
                `TSAC_ADDR_CONTROL: begin
                    // Start bit is a command, not stored
                    modeControl <= {xf.reqWrData[7:1], 1'b0};
                end
                default: begin
                    // Read-only and unmapped addresses ignore writes
                end
            endcase
        end
    end
    assign oneShotReq = wrEvent && (xf.reqAddr == `TSAC_ADDR_CONTROL)
        && xf.reqWrData[`TSAC_CTL_ONESHOT]; // R11

    // Mode from continuous and slow bits
    always_comb begin
        case ({modeControl[`TSAC_CTL_CONT], modeControl[`TSAC_CTL_SLOW]}) // R20
            2'b10: mode = TSAC_MODE_CONT;
            2'b01: mode = TSAC_MODE_SLOW; // R05
            2'b00: mode = TSAC_MODE_ONESHOT; // R19
            default: mode = TSAC_MODE_NONE; // R24: no conversions at all
        endcase
    end

    // Period: 1 Hz in slow mode, 200 Hz scaled by averaging in continuous
    always_comb begin
        if (mode == TSAC_MODE_SLOW) begin
            ratePeriod = 27'(SLOW_CYC - 1);
        end else begin
            ratePeriod = 27'((FAST_CYC << (2'd3 - modeControl[5:4])) - 1); // R07
        end
    end
    assign rateTick = (rateCount == ratePeriod);

    // Periodic timer runs only in periodic modes
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            rateCount <= '0;
        end else if (mode != TSAC_MODE_CONT && mode != TSAC_MODE_SLOW) begin
            rateCount <= '0;
        end else if (rateTick) begin
            rateCount <= '0;
        end else begin
            rateCount <= rateCount + 27'h1;
        end
    end

    // Conversion sequencer: start, wait for the chain, store result
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            convState <= TSAC_CONV_IDLE;
            convStart <= 1'b0;
            busy <= 1'b0;
        end else begin
            convStart <= 1'b0;
            case (convState)
                TSAC_CONV_IDLE: begin
                    if (oneShotReq && mode == TSAC_MODE_ONESHOT) begin
                        convStart <= 1'b1;
                        busy <= 1'b1; // R14
                        convState <= TSAC_CONV_WAIT;
                    end else if (rateTick) begin
                        convStart <= 1'b1; // R21
                        convState <= TSAC_CONV_WAIT;
                    end
                end
                TSAC_CONV_WAIT: begin
                    if (convDone) begin
                        busy <= 1'b0; // R14
                        convState <= TSAC_CONV_IDLE;
                    end
                end
                default: begin
                    convState <= TSAC_CONV_IDLE;
                end
            endcase
        end
    end

    // Chain stays on in periodic modes, on one-shot only while busy
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            chainPowerOn <= 1'b0;
        end else begin
            chainPowerOn <= (mode == TSAC_MODE_CONT) || (mode == TSAC_MODE_SLOW)
                || (convState == TSAC_CONV_WAIT) || convStart; // R19 R21
        end
    end

    // Result register, updated at each finished conversion
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            result <= `TSAC_RST_RESULT;
        end else if (convState == TSAC_CONV_WAIT && convDone) begin
            result <= convResult; // R15
        end
    end

    // Coherent update: high byte caught when low byte is read
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            highShadow <= 8'h00;
        end else if (rdEvent && xf.reqAddr == `TSAC_ADDR_RES_LOW) begin
            highShadow <= result[15:8]; // R06
        end
    end

    // Limit decode and compare on the incoming result
    assign highLimit = decodeLimit(highThreshold); // R01
    assign lowLimit = decodeLimit(lowThreshold); // R02
    assign overNow = (highThreshold != 8'h00)
        && ($signed(convResult) >= highLimit); // R03 R16
    assign underNow = (lowThreshold != 8'h00)
        && ($signed(convResult) < lowLimit); // R04 R16

    // Sticky flags: set with the result, cleared by status read, set wins
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            belowLowLimitFlag <= 1'b0;
            aboveHighLimitFlag <= 1'b0;
        end else begin
            if (convState == TSAC_CONV_WAIT && convDone && underNow) begin
                belowLowLimitFlag <= 1'b1; // R12 R25
            end else if (flagsRead) begin
                belowLowLimitFlag <= 1'b0; // R12
            end
            if (convState == TSAC_CONV_WAIT && convDone && overNow) begin
                aboveHighLimitFlag <= 1'b1; // R13 R25
            end else if (flagsRead) begin
                aboveHighLimitFlag <= 1'b0; // R13
            end
        end
    end

    // Alert latch: re-armed by each out-of-limit conversion, cleared by ack or status read
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            alertActive <= 1'b0;
        end else if (convState == TSAC_CONV_WAIT && convDone && (overNow || underNow)) begin
            alertActive <= 1'b1; // R16 R18 R25
        end else if (araEvent || flagsRead) begin
            alertActive <= 1'b0; // R17
        end
    end

    // Open-drain pin: value always low, enable follows the latch
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            alertOut <= 1'b0;
            alertOe <= 1'b0;
        end else begin
            alertOut <= 1'b0;
            alertOe <= alertActive; // R16
        end
    end

    // Control fields to the serial engine and the chain
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            busTimeoutDisable <= 1'b0;
            averagingSelect <= 2'h0;
        end else begin
            busTimeoutDisable <= modeControl[`TSAC_CTL_TMO_DIS]; // R10
            averagingSelect <= modeControl[`TSAC_CTL_AVG_HI:`TSAC_CTL_AVG_LO]; // R07
        end
    end

    // Read multiplexer; unmapped addresses read zero
    always_comb begin
        case (xf.reqAddr)
            `TSAC_ADDR_IDENTITY: next_rdByte = `TSAC_IDENTITY_VALUE;
            `TSAC_ADDR_HIGH_THR: next_rdByte = highThreshold;
            `TSAC_ADDR_LOW_THR: next_rdByte = lowThreshold;
            `TSAC_ADDR_CONTROL: next_rdByte = {modeControl[7:1], busy};
            `TSAC_ADDR_FLAGS: next_rdByte = {5'h00, belowLowLimitFlag,
                aboveHighLimitFlag, busy}; // R14
            `TSAC_ADDR_RES_LOW: next_rdByte = result[7:0];
            `TSAC_ADDR_RES_HIGH: next_rdByte = modeControl[`TSAC_CTL_COHERENT]
                ? highShadow : result[15:8]; // R06
            default: next_rdByte = 8'h00;
        endcase
    end

    // Answer: data first, then the ack toggle in the same edge
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            xf.ackRdData <= 8'h00;
            xf.ackToggle <= 1'b0;
        end else if (reqEvent) begin
            xf.ackRdData <= next_rdByte;
            xf.ackToggle <= reqSync[2];
        end
    end

    // Auto-advance level for the link side
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            xf.autoInc <= 1'b0;
        end else begin
            xf.autoInc <= modeControl[`TSAC_CTL_AUTOINC]; // R08 R09
        end
    end
endmodule

// file: dv/tsac_core_properties.sv
// Checker on the top ports of the sensor core
`timescale 1ns/1ps
module tsac_core_properties (
    input wire logic clk_sys, // Core clock
    input wire logic rst_b, // Reset, active low
    input wire logic linkClk, // Link clock
    input wire logic wrStrobe, // Write strobe
    input wire logic rdStrobe, // Read strobe
    input wire logic rdValid, // Read byte valid
    input wire logic linkBusy, // Access in flight
    input wire logic convStart, // Start pulse
    input wire logic convDone, // Done pulse
    input wire logic chainPowerOn, // Chain powered
    input wire logic alertOut, // Alert value
    input wire logic alertOe // Alert enable
);
    // Start is one pulse, then the chain is powered
    sequence s_start_power;
        convStart ##1 (!convStart && chainPowerOn);
    endsequence
    // A taken strobe raises busy on the next edge
    sequence s_taken;
        (wrStrobe || rdStrobe) && !linkBusy;
    endsequence
    a_start_power: assert property (@(posedge clk_sys) disable iff (!rst_b)
        convStart |-> s_start_power) else $error("chain not powered after start");
    a_start_gap: assert property (@(posedge clk_sys) disable iff (!rst_b)
        convStart |=> !convStart [*3]) else $error("start pulses too close");
    a_alert_value: assert property (@(posedge clk_sys) disable iff (!rst_b)
        alertOut == 1'b0) else $error("alert pin value not low");
    a_alert_cause: assert property (@(posedge clk_sys) disable iff (!rst_b)
        $rose(alertOe) |-> $past(convDone, 2)) else $error("alert rose without result");
    a_take_busy: assert property (@(posedge linkClk) disable iff (!rst_b)
        s_taken |=> linkBusy) else $error("strobe not taken");
    a_valid_pulse: assert property (@(posedge linkClk) disable iff (!rst_b)
        rdValid |=> !rdValid) else $error("read valid too long");
    a_valid_done: assert property (@(posedge linkClk) disable iff (!rst_b)
        $rose(rdValid) |-> !linkBusy && $past(linkBusy)) else $error("valid off busy end");
    a_busy_bound: assert property (@(posedge linkClk) disable iff (!rst_b)
        $rose(linkBusy) |-> ##[1:16] !linkBusy) else $error("access never ends");
endmodule
bind tsac_core tsac_core_properties u_props (.*);

// file: dv/tsac_host_model.sv
// Host model driving the link side of the sensor core
`timescale 1ns/1ps
module tsac_host_model (
    input wire logic linkClk, // Link clock
    input wire logic linkBusy, // Access in flight
    output logic subAddrLoad, // Pointer load pulse
    output logic [7:0] subAddr, // Pointer value
    output logic wrStrobe, // Write pulse
    output logic [7:0] wrData, // Write byte
    output logic rdStrobe, // Read pulse
    output logic araAck // Alert response pulse
);
    int errs = 0; // Accesses that never ended
    initial begin
        {subAddrLoad, wrStrobe, rdStrobe, araAck, subAddr, wrData} = 20'h00000;
    end
    // Optional pointer load, one strobe, then wait for idle
    task automatic xfer(input logic ld, input logic [7:0] a, input logic rd,
                        input logic [7:0] d);
        int n;
        n = 0;
        repeat ($urandom % 3) @(negedge linkClk);
        subAddrLoad = ld;
        subAddr = a;
        @(negedge linkClk);
        subAddrLoad = 1'b0;
        subAddr = ~a;
        rdStrobe = rd;
        wrStrobe = !rd;
        wrData = d;
        @(negedge linkClk);
        rdStrobe = 1'b0;
        wrStrobe = 1'b0;
        wrData = ~d;
        while (linkBusy !== 1'b0 && n < 20) begin
            @(negedge linkClk);
            n++;
        end
        if (n == 20) errs++;
    endtask
    // One acknowledged alert response
    task automatic ara();
        araAck = 1'b1;
        @(negedge linkClk);
        araAck = 1'b0;
    endtask
endmodule

// file: dv/test_temp_sensor_register_alert_core.sv
// Self-checking bench of the sensor core
`timescale 1ns/1ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin err_count++; \
    $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module test_temp_sensor_register_alert_core;
    logic clk_sys = 0, linkClk = 0, rst_b = 0, convDone = 0; // Clocks, chain done
    logic subAddrLoad, wrStrobe, rdStrobe, araAck, rdValid, linkBusy, tmoDis;
    logic convStart, chainPowerOn, alertOut, alertOe; // Chain and alert
    logic [7:0] subAddr, wrData, rdData, h, e; // Link bytes
    logic [15:0] convResult = 0, res = 0; // Chain result
    logic [1:0] avgSel, av; // Averaging code
    logic [7:0] expQ[$]; // Expected read bytes
    logic [7:0] rstExp[8] = '{8'h5c, 0, 0, 0, 0, 0, 0, 0}; // Values after reset
    int err_count = 0, total_checks = 0, cd = 0, n, lim;
    tsac_host_model host (.*);
    tsac_core #(.SLOW_CYC(200), .FAST_CYC(20)) dut (.*, .busTimeoutDisable(tmoDis),
        .averagingSelect(avgSel));
    always #5 clk_sys = ~clk_sys;
    initial begin
        #17;
        forever #62.5 linkClk = ~linkClk;
    end
    // Chain model: result some 400 cycles after each start
    always @(negedge clk_sys) begin
        convDone <= 1'b0;
        if (convStart === 1'b1) cd <= 400;
        else if (cd == 1) begin
            convDone <= 1'b1;
            convResult <= res;
            cd <= 0;
        end else if (cd > 1) cd <= cd - 1;
    end
    // Read monitor takes the oldest expected byte
    always @(posedge linkClk) if (rdValid === 1'b1) begin
        e = expQ.size() ? expQ.pop_front() : 8'hxx;
        `CHK(rdData, e)
    end
    task automatic wr(input logic ld, input logic [7:0] a, input logic [7:0] d);
        host.xfer(ld, a, 1'b0, d);
    endtask
    task automatic rd(input logic ld, input logic [7:0] a, input logic [7:0] x);
        expQ.push_back(x);
        host.xfer(ld, a, 1'b1, 8'h00);
    endtask
    // One-shot conversion with the status seen while it runs
    task automatic conv(input logic [15:0] r, input logic [7:0] c, input logic [7:0] s);
        res = r;
        wr(1, 8'h04, c);
        rd(1, 8'h05, s);
        n = 0;
        while (convDone !== 1'b1 && n < 2000) begin
            @(posedge clk_sys);
            n++;
        end
        if (n == 2000) err_count++;
        repeat (4) @(negedge clk_sys);
    endtask
    task automatic report_and_stop();
        err_count += host.errs;
        $display("checks=%0d errors=%0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    initial begin
        #500000;
        err_count++;
        report_and_stop();
    end
    initial begin
        void'($urandom(93675));
        repeat (10) @(negedge linkClk);
        rst_b = 1'b1;
        repeat (6) @(negedge linkClk);
        foreach (rstExp[i]) rd(1, 8'(i + 1), rstExp[i]);
        h = 8'(65 + $urandom % 100);
        wr(1, 8'h04, 8'h08);
        wr(1, 8'h02, h);
        wr(0, 8'h00, h - 8'h01);
        rd(1, 8'h02, h);
        rd(0, 8'h00, h - 8'h01);
        wr(1, 8'h04, 8'h00);
        wr(1, 8'h03, 8'haa);
        wr(0, 8'h00, h - 8'h01);
        rd(1, 8'h03, h - 8'h01);
        rd(0, 8'h00, h - 8'h01);
        lim = (int'(h) - 63) * 64;
        conv(16'(lim), 8'h41, 8'h01);
        `CHK(alertOe, 1'b1)
        rd(1, 8'h05, 8'h02);
        `CHK(alertOe, 1'b0)
        rd(1, 8'h05, 8'h00);
        rd(1, 8'h06, lim[7:0]);
        rd(1, 8'h07, lim[15:8]);
        conv(16'(lim - 65), 8'h01, 8'h01);
        `CHK(alertOe, 1'b1)
        host.ara();
        repeat (8) @(negedge linkClk);
        `CHK(alertOe, 1'b0)
        conv(16'(lim - 65), 8'h01, 8'h05);
        `CHK(alertOe, 1'b1)
        rd(1, 8'h05, 8'h04);
        wr(1, 8'h02, 8'h00);
        wr(1, 8'h03, 8'h00);
        conv(16'h8000, 8'h01, 8'h01);
        conv(16'h7fff, 8'h01, 8'h01);
        `CHK(alertOe, 1'b0)
        rd(1, 8'h05, 8'h00);
        av = 2'($urandom % 4);
        wr(1, 8'h04, {2'b00, av, 4'b0110});
        `CHK(avgSel, av)
        `CHK(tmoDis, 1'b1)
        repeat (2) begin
            n = 0;
            while (convStart !== 1'b1 && n < 3000) begin
                @(posedge clk_sys);
                n++;
            end
            @(negedge clk_sys);
            `CHK(chainPowerOn, 1'b1)
        end
        wr(1, 8'h04, 8'h00);
        wr(1, 8'h04, 8'h80);
        n = 0;
        while (convStart !== 1'b1 && n < 3000) begin
            @(posedge clk_sys);
            n++;
        end
        `CHK(n < 700, 1'b1)
        wr(1, 8'h04, 8'h00);
        `CHK(expQ.size(), 0)
        report_and_stop();
    end
endmodule
